// >>> rtl/uief_params.svh
`ifndef UIEF_PARAMS_SVH
`define UIEF_PARAMS_SVH

// register byte offsets
`define UIEF_RAW_OFS 12'h08c
`define UIEF_EN_OFS 12'h090
`define UIEF_FRC_OFS 12'h094
`define UIEF_MASKED_OFS 12'h098
`define UIEF_EVT_ST_OFS 12'h0a0
`define UIEF_EVT_MASK_OFS 12'h0a4

// source bit positions
`define UIEF_B_STALL_NAK 19
`define UIEF_B_ABORT 18
`define UIEF_B_DEVICE_FRAME_START_SEEN 17
`define UIEF_B_SETUP 16
`define UIEF_B_DEV_WAKE 15
`define UIEF_B_DEV_SLEEP 14
`define UIEF_B_DEV_ATTACH 13
`define UIEF_B_BUS_RESET 12
`define UIEF_B_MIRROR_LO 5
`define UIEF_B_BUF_DONE 4
`define UIEF_B_XFER_DONE 3
`define UIEF_B_HOST_SOF 2
`define UIEF_B_HOST_WAKE 1
`define UIEF_B_HOST_ATTACH 0

// reset values
`define UIEF_EN_RST 20'h00000
`define UIEF_FRC_RST 20'h00000
`define UIEF_EVT_MASK_RST 20'h00000
`define UIEF_SRC_RST 20'h00000

`endif

// >>> rtl/uief_pkg.sv
package uief_pkg;

  localparam int unsigned UIEF_SRC_W = 20;
  localparam int unsigned UIEF_EP_W = 32;

  // level flags from the controller status register
  typedef struct packed {
    logic setup_rec;
    logic bus_reset;
    logic vbus_detected;
    logic stall_rec;
    logic crc_error;
    logic bit_stuff_error;
    logic rx_overflow;
    logic rx_timeout;
    logic data_seq_error;
    logic transfer_finished;
    logic suspended;
    logic connected;
    logic [1:0] speed;
  } uief_engine_type;

  // one-cycle event pulses from the serial engine
  typedef struct packed {
    logic device_frame_start_seen;
    logic host_sof;
    logic dev_resume;
    logic host_resume;
  } uief_pulse_type;

  // one-cycle software access pulses seen by other registers
  typedef struct packed {
    logic frame_num_rd;
    logic resume_wr;
    logic suspended_wr;
    logic connected_wr;
    logic speed_wr;
  } uief_clear_type;

  typedef enum logic [2:0] {
    UIEF_REG_RAW,
    UIEF_REG_EN,
    UIEF_REG_FRC,
    UIEF_REG_MASKED,
    UIEF_REG_EVT_ST,
    UIEF_REG_EVT_MASK,
    UIEF_REG_NONE
  } uief_reg_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rd_evt;
    logic primed;
    logic [UIEF_SRC_W-1:0] enable;
    logic [UIEF_SRC_W-1:0] frc;
    logic [UIEF_SRC_W-1:0] latched;
    logic [UIEF_SRC_W-1:0] raw;
    logic [UIEF_SRC_W-1:0] masked;
    logic [UIEF_SRC_W-1:0] evt_status;
    logic [UIEF_SRC_W-1:0] evt_mask;
    logic irq;
    logic irq_evt;
    logic trans_prev;
    logic susp_prev;
    logic conn_prev;
    logic [1:0] speed_prev;
  } uief_state_type;

endpackage

// >>> rtl/uief_top.sv
// How it works
// - An enable register at 0x90 holds one read-write enable per source in bits 19:0, bits 31:20 read zero, all enables reset to zero.
// - A force register at 0x94 holds one read-write bit per source in bits 19:0 that asserts that source whatever the raw event, reset zero.
// - Source 19 is high while any endpoint stall-or-NAK flag is set and falls only when software has cleared them all.
// - Source 18 is high while any endpoint abort-done flag is set and stays high until software clears them all.
// - In device role source 17 sets on each received frame start and clears when the frame-number register is read.
// - Sources 16 and 12 down to 5 mirror setup, bus reset, supply, stall, CRC, bit-stuff, overflow, timeout and sequence flags in that order.
// - Source 15 sets on resume signalling from the host and clears when software writes the resume flag of the engine status.
// - Source 14 sets on every change of the suspend state and clears when software writes the suspended flag.
// - Source 13 sets on every change of the connection state and clears when software writes the connected flag.
// - Source 4 is high while any endpoint buffer flag is set and stays high until software clears them all.
// - Source 3 sets each time the transfer-finished flag rises and clears when software writes a one to it.
// - In host role source 2 sets on each frame start sent and clears when the frame-number register is read.
// - In host role source 1 sets on remote wakeup from the peripheral and clears when software writes the resume flag.
// - In host role source 0 sets when the attached-device speed changes and clears when software writes the speed field.
// - The masked status at 0x98 is each raw source ANDed with its enable and then ORed with its force bit.
`timescale 1ns/10ps
`default_nettype none
`include "uief_params.svh"

module uief_top
  import uief_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // controller sources
  input wire logic HOST_MODE,
  input wire logic [UIEF_EP_W-1:0] ENDPOINT_STALL_OR_NAK_FLAGS,
  input wire logic [UIEF_EP_W-1:0] ABORT_DONE_FLAGS,
  input wire logic [UIEF_EP_W-1:0] BUFFER_DONE_FLAGS,
  input wire uief_engine_type ENGINE_STATUS,
  input wire uief_pulse_type ENGINE_PULSE,
  input wire uief_clear_type SOFT_CLEAR,
  // interrupt results
  output logic [UIEF_SRC_W-1:0] IRQ_MASKED_STATUS,
  output logic IRQ,
  output logic IRQ_EVENT
);

  uief_state_type s_reg;
  uief_state_type s_next;

  function automatic uief_reg_type reg_decode(input logic [11:0] addr);
    unique case (addr)
      `UIEF_RAW_OFS: reg_decode = UIEF_REG_RAW;
      `UIEF_EN_OFS: reg_decode = UIEF_REG_EN;
      `UIEF_FRC_OFS: reg_decode = UIEF_REG_FRC;
      `UIEF_MASKED_OFS: reg_decode = UIEF_REG_MASKED;
      `UIEF_EVT_ST_OFS: reg_decode = UIEF_REG_EVT_ST;
      `UIEF_EVT_MASK_OFS: reg_decode = UIEF_REG_EVT_MASK;
      default: reg_decode = UIEF_REG_NONE;
    endcase
  endfunction

  logic [UIEF_SRC_W-1:0] level_src;
  logic [UIEF_SRC_W-1:0] set_src;
  logic [UIEF_SRC_W-1:0] clr_src;
  logic [UIEF_SRC_W-1:0] rd_clr;
  logic [UIEF_SRC_W-1:0] read_val;
  logic [UIEF_SRC_W-1:0] sticky_next;
  logic [UIEF_SRC_W-1:0] raw_next;
  logic [UIEF_SRC_W-1:0] masked_next;
  logic [UIEF_SRC_W-1:0] evt_next;
  logic setup_ph;
  logic access_ph;
  logic wr_ok;
  uief_reg_type setup_sel;
  uief_reg_type access_sel;

  always_comb begin
    s_next = s_reg;
    setup_ph = PSEL && !PENABLE;
    access_ph = PSEL && PENABLE && s_reg.pready;
    setup_sel = reg_decode(PADDR);
    access_sel = reg_decode(PADDR);
    wr_ok = access_ph && PWRITE;

    // sources that follow a level and need no latch
    level_src = '0;
    level_src[`UIEF_B_STALL_NAK] = |ENDPOINT_STALL_OR_NAK_FLAGS;
    level_src[`UIEF_B_ABORT] = |ABORT_DONE_FLAGS;
    level_src[`UIEF_B_SETUP] = ENGINE_STATUS.setup_rec;
    level_src[`UIEF_B_BUS_RESET:`UIEF_B_MIRROR_LO] = {
      ENGINE_STATUS.bus_reset, ENGINE_STATUS.vbus_detected,
      ENGINE_STATUS.stall_rec, ENGINE_STATUS.crc_error,
      ENGINE_STATUS.bit_stuff_error, ENGINE_STATUS.rx_overflow,
      ENGINE_STATUS.rx_timeout, ENGINE_STATUS.data_seq_error};
    level_src[`UIEF_B_BUF_DONE] = |BUFFER_DONE_FLAGS;

    // change detectors stay quiet until one cycle after reset
    set_src = '0;
    set_src[`UIEF_B_DEVICE_FRAME_START_SEEN] = ENGINE_PULSE.device_frame_start_seen && !HOST_MODE;
    set_src[`UIEF_B_DEV_WAKE] = ENGINE_PULSE.dev_resume;
    set_src[`UIEF_B_DEV_SLEEP] = s_reg.primed &&
      (ENGINE_STATUS.suspended != s_reg.susp_prev);
    set_src[`UIEF_B_DEV_ATTACH] = s_reg.primed &&
      (ENGINE_STATUS.connected != s_reg.conn_prev);
    set_src[`UIEF_B_XFER_DONE] = s_reg.primed &&
      ENGINE_STATUS.transfer_finished && !s_reg.trans_prev;
    set_src[`UIEF_B_HOST_SOF] = ENGINE_PULSE.host_sof && HOST_MODE;
    set_src[`UIEF_B_HOST_WAKE] = ENGINE_PULSE.host_resume && HOST_MODE;
    set_src[`UIEF_B_HOST_ATTACH] = HOST_MODE && s_reg.primed &&
      (ENGINE_STATUS.speed != s_reg.speed_prev);

    clr_src = '0;
    clr_src[`UIEF_B_DEVICE_FRAME_START_SEEN] = SOFT_CLEAR.frame_num_rd;
    clr_src[`UIEF_B_DEV_WAKE] = SOFT_CLEAR.resume_wr;
    clr_src[`UIEF_B_DEV_SLEEP] = SOFT_CLEAR.suspended_wr;
    clr_src[`UIEF_B_DEV_ATTACH] = SOFT_CLEAR.connected_wr;
    clr_src[`UIEF_B_XFER_DONE] = wr_ok &&
      access_sel == UIEF_REG_RAW && PWDATA[`UIEF_B_XFER_DONE];
    clr_src[`UIEF_B_HOST_SOF] = SOFT_CLEAR.frame_num_rd;
    clr_src[`UIEF_B_HOST_WAKE] = SOFT_CLEAR.resume_wr;
    clr_src[`UIEF_B_HOST_ATTACH] = SOFT_CLEAR.speed_wr;

    // a new event wins over a clear in the same cycle
    sticky_next = (s_reg.latched & ~clr_src) | set_src;
    s_next.latched = sticky_next;
    s_next.primed = 1'b1;
    s_next.trans_prev = ENGINE_STATUS.transfer_finished;
    s_next.susp_prev = ENGINE_STATUS.suspended;
    s_next.conn_prev = ENGINE_STATUS.connected;
    s_next.speed_prev = ENGINE_STATUS.speed;

    // register writes land at the access edge
    if (wr_ok && access_sel == UIEF_REG_EN) begin
      s_next.enable = PWDATA[UIEF_SRC_W-1:0];
    end
    if (wr_ok && access_sel == UIEF_REG_FRC) begin
      s_next.frc = PWDATA[UIEF_SRC_W-1:0];
    end
    if (wr_ok && access_sel == UIEF_REG_EVT_MASK) begin
      s_next.evt_mask = PWDATA[UIEF_SRC_W-1:0];
    end

    raw_next = sticky_next | level_src;
    s_next.raw = raw_next;
    masked_next = (raw_next & s_next.enable) | s_next.frc;
    s_next.masked = masked_next;
    s_next.irq = |masked_next;

    // rising masked bits latch into the read-clear event status
    rd_clr = '0;
    if (access_ph && s_reg.rd_evt) begin
      rd_clr = s_reg.prdata[UIEF_SRC_W-1:0];
    end
    evt_next = (s_reg.evt_status & ~rd_clr) | (masked_next & ~s_reg.masked);
    s_next.evt_status = evt_next;
    s_next.irq_evt = |(evt_next & s_next.evt_mask);

    // read data is captured in the setup cycle, answered one cycle later
    read_val = '0;
    unique case (setup_sel)
      UIEF_REG_RAW: read_val = s_reg.raw;
      UIEF_REG_EN: read_val = s_reg.enable;
      UIEF_REG_FRC: read_val = s_reg.frc;
      UIEF_REG_MASKED: read_val = s_reg.masked;
      UIEF_REG_EVT_ST: read_val = s_reg.evt_status;
      UIEF_REG_EVT_MASK: read_val = s_reg.evt_mask;
      UIEF_REG_NONE: read_val = '0;
    endcase
    s_next.pready = setup_ph;
    s_next.pslverr = setup_ph && setup_sel == UIEF_REG_NONE;
    s_next.rd_evt = setup_ph && !PWRITE && setup_sel == UIEF_REG_EVT_ST;
    s_next.prdata = '0;
    if (setup_ph && !PWRITE) begin
      s_next.prdata = {12'h000, read_val};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_reg <= '0;
      s_reg.enable <= `UIEF_EN_RST;
      s_reg.frc <= `UIEF_FRC_RST;
      s_reg.evt_mask <= `UIEF_EVT_MASK_RST;
      s_reg.latched <= `UIEF_SRC_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign IRQ_MASKED_STATUS = s_reg.masked;
  assign IRQ = s_reg.irq;
  assign IRQ_EVENT = s_reg.irq_evt;

endmodule

`default_nettype wire

// >>> tb/uief_checker.sv
`timescale 1ns/10ps
`default_nettype none
module uief_checker
  import uief_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // results
  input wire logic [UIEF_SRC_W-1:0] IRQ_MASKED_STATUS,
  input wire logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence read_s(logic [11:0] a);
    PSEL && PENABLE && PREADY && !PWRITE && PADDR == a;
  endsequence
  answer_a: assert property (setup_s |=> PREADY && PENABLE)
    else $error("no answer after setup");
  one_wait_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  err_addr_a: assert property (PREADY |-> PSLVERR == !(PADDR inside
    {12'h08c, 12'h090, 12'h094, 12'h098, 12'h0a0, 12'h0a4}))
    else $error("error flag wrong");
  idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  en_top_a: assert property (read_s(12'h090) |-> PRDATA[31:20] == 12'h0)
    else $error("enable top bits set");
  frc_top_a: assert property (read_s(12'h094) |-> PRDATA[31:20] == 12'h0)
    else $error("force top bits set");
  masked_rd_a: assert property (read_s(12'h098) |->
    PRDATA == {12'h0, $past(IRQ_MASKED_STATUS)})
    else $error("masked readback wrong");
  irq_any_a: assert property (IRQ == (|IRQ_MASKED_STATUS))
    else $error("irq differs from status");
endmodule
bind uief_top uief_checker uief_checker_inst (.CORE_CLK, .RST_N, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .IRQ_MASKED_STATUS, .IRQ);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import uief_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0, host_mode = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, flags = 32'h0, prdata, rdat;
  uief_engine_type eng = '0;
  uief_pulse_type pul = '0;
  uief_clear_type clr = '0;
  logic pready, pslverr, irq, irq_evt, rerr;
  logic [19:0] ms;
  int fail_count = 0, total_checks = 0;
  int unsigned pos[9] = '{16, 12, 11, 10, 9, 8, 7, 6, 5};

  always #25 core_clk = ~core_clk;

  uief_top uief_top_inst (.CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HOST_MODE(host_mode), .ENDPOINT_STALL_OR_NAK_FLAGS(flags),
    .ABORT_DONE_FLAGS(flags), .BUFFER_DONE_FLAGS(flags),
    .ENGINE_STATUS(eng), .ENGINE_PULSE(pul), .SOFT_CLEAR(clr),
    .IRQ_MASKED_STATUS(ms), .IRQ(irq), .IRQ_EVENT(irq_evt));

  task automatic chk(input logic [31:0] g, input logic [31:0] x,
    input string m);
    total_checks++;
    fail_count += int'(g !== x);
    if (g !== x) $display("BAD %0t %s", $time, m);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one apb transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    #1;
    while (pready !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    // answer stands until the next edge, which closes the access
    rdat = prdata;
    rerr = pslverr;
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
    input string m);
    apb(1'b0, a, 32'h0);
    chk(rdat, x, m);
  endtask

  // drive sources for one cycle of pulses, then compare masked status
  task automatic step(input logic [19:0] x, input string m,
    input logic [31:0] f = 32'h0, input logic [13:0] e = 14'h0,
    input logic [3:0] p = 4'h0, input logic [4:0] c = 5'h0);
    @(posedge core_clk);
    flags <= f;
    eng <= uief_engine_type'(e);
    pul <= uief_pulse_type'(p);
    clr <= uief_clear_type'(c);
    @(posedge core_clk);
    pul <= '0;
    clr <= '0;
    @(posedge core_clk);
    #1;
    chk({12'h0, ms}, {12'h0, x}, m);
  endtask

  task automatic t_regs();
    rd(12'h090, 32'h0, "en rst");
    rd(12'h094, 32'h0, "frc rst");
    apb(1'b1, 12'h094, 32'hfff00005);
    rd(12'h094, 32'h00000005, "frc rw");
    step(20'h00005, "forced");
    chk(irq, 1'b1, "irq on");
    rd(12'h098, 32'h00000005, "masked rd");
    apb(1'b1, 12'h0a4, 32'h00000004);
    step(20'h00005, "hold");
    chk(irq_evt, 1'b1, "evt on");
    rd(12'h0a0, 32'h00000005, "evt rd");
    apb(1'b1, 12'h094, 32'h0);
    step(20'h00000, "unforced");
    chk(irq, 1'b0, "irq off");
    chk(irq_evt, 1'b0, "evt off");
    apb(1'b1, 12'h098, 32'hffffffff);
    rd(12'h000, 32'h0, "bad addr");
    chk(rerr, 1'b1, "no error");
    rd(12'h098, 32'h0, "masked ro");
  endtask

  task automatic t_levels();
    step(20'h00000, "gated", 32'h80000001);
    apb(1'b1, 12'h090, 32'hffffffff);
    rd(12'h090, 32'h000fffff, "en rw");
    step(20'hc0010, "one left", 32'h80000000);
    step(20'h00000, "all clear");
    for (int i = 0; i < 9; i++) begin
      step(20'h1 << pos[i], "mirror", 32'h0, 14'h2000 >> i);
    end
  endtask

  task automatic t_sticky();
    step(20'h20000, "dsof", 32'h0, 14'h0, 4'h8);
    step(20'h20000, "hsof gated", 32'h0, 14'h0, 4'h4);
    step(20'h00000, "sof rd", 32'h0, 14'h0, 4'h0, 5'h10);
    @(posedge core_clk);
    host_mode <= 1'b1;
    step(20'h00004, "hsof", 32'h0, 14'h0, 4'h4);
    step(20'h00004, "dsof gated", 32'h0, 14'h0, 4'h8);
    step(20'h00006, "hwake", 32'h0, 14'h0, 4'h1);
    step(20'h08006, "dwake", 32'h0, 14'h0, 4'h2);
    step(20'h00000, "wake clr", 32'h0, 14'h0, 4'h0, 5'h18);
    step(20'h06009, "changes", 32'h0, 14'h001d);
    step(20'h02009, "sleep clr", 32'h0, 14'h001d, 4'h0, 5'h04);
    step(20'h00009, "attach clr", 32'h0, 14'h001d, 4'h0, 5'h02);
    step(20'h00008, "speed clr", 32'h0, 14'h001d, 4'h0, 5'h01);
    apb(1'b1, 12'h08c, 32'h00000008);
    step(20'h00000, "done clr", 32'h0, 14'h001d);
    step(20'h06001, "fall", 32'h0, 14'h0010);
  endtask

  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_levels();
    t_sticky();
    give_verdict();
  end
endmodule
`default_nettype wire
